// ===== rtl/counter_array_watchdog.sv
`timescale 1ns/10ps
module counter_array_watchdog (
    input  wire logic       i_core_clk,     // system clock, 125 MHz
    input  wire logic       i_rst_b,        // sync reset, low
    input  wire logic [7:0] i_sfr_addr,     // register address
    input  wire logic       i_sfr_wr,       // write strobe
    input  wire logic       i_sfr_rd,       // read strobe
    input  wire logic [7:0] i_sfr_wdata,    // write data
    output logic      [7:0] o_sfr_rdata,    // read data, held
    input  wire logic       i_cpu_idle,     // processor in idle
    input  wire logic       i_timer0_ovf,   // timer 0 overflow pulse
    input  wire logic       i_ext_count,    // external count input
    input  wire logic       i_ext_clk,      // external clock
    input  wire logic [counter_array_pkg::NUM_CHANNELS-2:0] i_chan_match,
    output logic            o_watchdog_reset, // reset request pulse
    output logic            o_counter_irq,    // overflow interrupt
    output logic            o_watchdog_active // watchdog enabled
);
    import counter_array_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        cf_r, cf_nxt, cr_r, cr_nxt;
    logic [NUM_CHANNELS-1:0] ccf_r, ccf_nxt, ccf_set;
    logic        idle_suspend_bit_r, idle_suspend_bit_nxt, watchdog_enable_bit_r, watchdog_enable_bit_nxt;
    logic        lock_r, lock_nxt, oie_r, oie_nxt;
    logic [2:0]  tb_r, tb_nxt;
    logic [15:0] count_r, count_nxt;
    logic [7:0]  cpl5_r, cpl5_nxt, cph5_r, cph5_nxt;
    logic [7:0]  cpm5_r, cpm5_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        irq_r, irq_nxt, active_r;
    logic        wd_en, run, tick, low_ovf, wrap, ch5_match;
    logic        force_trip;
    logic        wr_ctl, wr_mode, wr_cpm5, wr_lo, wr_hi;
    logic        wr_cpl5, wr_cph5;

    // ------------------------------------------------------------
    // enable, run and decode
    // ------------------------------------------------------------
    assign wd_en = watchdog_enable_bit_r | lock_r;
    assign run = (cr_r | wd_en) & ~(i_cpu_idle & idle_suspend_bit_r);
    assign low_ovf = tick & (count_r[7:0] == BYTE_MAX);
    assign wrap = tick & (count_r == COUNT_MAX);
    assign ch5_match = ~wd_en & tick & cpm5_r[CH5_MAT_BIT]
                       & (count_r == {cph5_r, cpl5_r});
    assign ccf_set = {ch5_match, i_chan_match};
    assign force_trip = wr_ctl & i_sfr_wdata[CH5_FLAG_BIT]
                        & wd_en;

    // address decoding for writes
    always_comb
    begin
        wr_ctl = 1'b0;
        wr_mode = 1'b0;
        wr_cpm5 = 1'b0;
        wr_lo = 1'b0;
        wr_hi = 1'b0;
        wr_cpl5 = 1'b0;
        wr_cph5 = 1'b0;
        if (!i_sfr_wr)
            wr_ctl = 1'b0;
        else if (i_sfr_addr == ADDR_CONTROL)
            wr_ctl = 1'b1;
        else if (i_sfr_addr == ADDR_MODE)
            wr_mode = 1'b1;
        else if (i_sfr_addr == ADDR_CH5_MODE)
            wr_cpm5 = 1'b1;
        else if (i_sfr_addr == ADDR_COUNT_LOW)
            wr_lo = 1'b1;
        else if (i_sfr_addr == ADDR_COUNT_HIGH)
            wr_hi = 1'b1;
        else if (i_sfr_addr == ADDR_CH5_LOW)
            wr_cpl5 = 1'b1;
        else if (i_sfr_addr == ADDR_CH5_HIGH)
            wr_cph5 = 1'b1;
    end

    // ------------------------------------------------------------
    // timebase and watchdog trip
    // ------------------------------------------------------------
    counter_tick_gen u_tick (
        .i_core_clk     (i_core_clk),
        .i_rst_b        (i_rst_b),
        .i_run          (run),
        .i_timebase_sel (tb_r),
        .i_timer0_ovf   (i_timer0_ovf),
        .i_ext_count    (i_ext_count),
        .i_ext_clk      (i_ext_clk),
        .o_tick         (tick)
    );

    watchdog_trip u_trip (
        .i_core_clk     (i_core_clk),
        .i_rst_b        (i_rst_b),
        .i_enable       (wd_en),
        .i_low_ovf      (low_ovf),
        .i_count_high   (count_r[15:8]),
        .i_compare_high (cph5_r),
        .i_force        (force_trip),
        .o_reset_req    (o_watchdog_reset)
    );

    // ------------------------------------------------------------
    // control register: hardware set wins over software clear
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CHANNELS; g++)
        begin : g_flag
            assign ccf_nxt[g] = ccf_set[g] |
                                (wr_ctl ? i_sfr_wdata[g] : ccf_r[g]);
        end
    endgenerate

    always_comb
    begin
        cf_nxt = wrap | (wr_ctl ? i_sfr_wdata[CTL_OVF_BIT] : cf_r);
        cr_nxt = wr_ctl ? i_sfr_wdata[CTL_RUN_BIT] : cr_r;
        irq_nxt = cf_r & oie_r;
    end

    // ------------------------------------------------------------
    // mode register: idle, timebase and interrupt enable bits frozen while the watchdog is enabled
    // ------------------------------------------------------------
    always_comb
    begin
        idle_suspend_bit_nxt = idle_suspend_bit_r;
        watchdog_enable_bit_nxt = watchdog_enable_bit_r;
        lock_nxt = lock_r;
        tb_nxt = tb_r;
        oie_nxt = oie_r;
        if (wr_mode)
        begin
            lock_nxt = lock_r | i_sfr_wdata[MODE_LOCK_BIT];
            if (!lock_r)
                watchdog_enable_bit_nxt = i_sfr_wdata[MODE_WATCHDOG_ENABLE_BIT_BIT];
            if (!wd_en)
            begin
                idle_suspend_bit_nxt = i_sfr_wdata[MODE_IDLE_BIT];
                tb_nxt = i_sfr_wdata[MODE_TB_MSB:MODE_TB_LSB];
                oie_nxt = i_sfr_wdata[MODE_OIE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // counter and channel 5 registers
    // ------------------------------------------------------------
    always_comb
    begin
        count_nxt = tick ? 16'(count_r + 16'h1) : count_r;
        if (wr_lo && !wd_en)
            count_nxt[7:0] = i_sfr_wdata;
        if (wr_hi && !wd_en)
            count_nxt[15:8] = i_sfr_wdata;
        cpl5_nxt = wr_cpl5 ? i_sfr_wdata : cpl5_r;
        cph5_nxt = cph5_r;
        if (wr_cph5)
            cph5_nxt = wd_en ? 8'(count_r[15:8] + cpl5_r)
                             : i_sfr_wdata;
        cpm5_nxt = (wr_cpm5 && !wd_en) ? i_sfr_wdata : cpm5_r;
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (!i_sfr_rd)
            rdata_nxt = rdata_r;
        else if (i_sfr_addr == ADDR_CONTROL)
            rdata_nxt = {cf_r, cr_r, ccf_r};
        else if (i_sfr_addr == ADDR_MODE)
            rdata_nxt = {idle_suspend_bit_r, watchdog_enable_bit_r, lock_r, 1'b0, tb_r, oie_r};
        else if (i_sfr_addr == ADDR_CH5_MODE)
            rdata_nxt = wd_en ? SW_TIMER_MODE : cpm5_r;
        else if (i_sfr_addr == ADDR_COUNT_LOW)
            rdata_nxt = count_r[7:0];
        else if (i_sfr_addr == ADDR_COUNT_HIGH)
            rdata_nxt = count_r[15:8];
        else if (i_sfr_addr == ADDR_CH5_LOW)
            rdata_nxt = cpl5_r;
        else if (i_sfr_addr == ADDR_CH5_HIGH)
            rdata_nxt = cph5_r;
        else
            rdata_nxt = BYTE_RESET;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            cf_r     <= 1'b0;
            cr_r     <= 1'b0;
            ccf_r    <= '0;
            idle_suspend_bit_r   <= 1'b0;
            watchdog_enable_bit_r   <= WATCHDOG_ENABLE_BIT_RESET;
            lock_r   <= 1'b0;
            tb_r     <= TB_DIV12;
            oie_r    <= 1'b0;
            count_r  <= '0;
            cpl5_r   <= BYTE_RESET;
            cph5_r   <= BYTE_RESET;
            cpm5_r   <= BYTE_RESET;
            rdata_r  <= BYTE_RESET;
            irq_r    <= 1'b0;
            active_r <= 1'b0;
        end
        else
        begin
            cf_r     <= cf_nxt;
            cr_r     <= cr_nxt;
            ccf_r    <= ccf_nxt;
            idle_suspend_bit_r   <= idle_suspend_bit_nxt;
            watchdog_enable_bit_r   <= watchdog_enable_bit_nxt;
            lock_r   <= lock_nxt;
            tb_r     <= tb_nxt;
            oie_r    <= oie_nxt;
            count_r  <= count_nxt;
            cpl5_r   <= cpl5_nxt;
            cph5_r   <= cph5_nxt;
            cpm5_r   <= cpm5_nxt;
            rdata_r  <= rdata_nxt;
            irq_r    <= irq_nxt;
            active_r <= watchdog_enable_bit_nxt | lock_nxt;
        end
    end

    assign o_sfr_rdata = rdata_r;
    assign o_counter_irq = irq_r;
    assign o_watchdog_active = active_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [12:0] boot_cnt_r;
    logic        quiet_r;

    // cycles since reset while software has written nothing
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            boot_cnt_r <= '0;
            quiet_r    <= 1'b1;
        end
        else
        begin
            boot_cnt_r <= 13'(boot_cnt_r + 13'h1);
            quiet_r    <= quiet_r & ~i_sfr_wr;
        end
    end

    a_boot_enabled:
    assert property (@(posedge i_core_clk)
        $rose(i_rst_b) |-> wd_en && tb_r == TB_DIV12)
    else $error("watchdog not enabled after reset");

    a_default_timeout:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (quiet_r && o_watchdog_reset) |->
            boot_cnt_r == 13'(DEFAULT_CYCLES + 1))
    else $error("default timeout not 3072 cycles");

    a_counter_forced:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wd_en && tick) |=> count_r == 16'($past(count_r) + 16'h1))
    else $error("counter not advancing under watchdog");

    a_tb_frozen:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wd_en && wr_mode) |=> $stable(tb_r) && $stable(idle_suspend_bit_r))
    else $error("timebase changed while watchdog on");

    a_ch5_mode_locked:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wd_en && wr_cpm5) |=> $stable(cpm5_r))
    else $error("channel 5 mode written while watchdog on");

    a_run_readback:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_sfr_rd && i_sfr_addr == ADDR_CONTROL && !cr_r)
            |=> !o_sfr_rdata[CTL_RUN_BIT])
    else $error("run bit read as set");

    a_trip_on_match:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wd_en && low_ovf && cph5_r == count_r[15:8])
            |=> o_watchdog_reset)
    else $error("missed watchdog timeout");

    a_service_reload:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wd_en && wr_cph5) |=>
            cph5_r == 8'($past(count_r[15:8]) + $past(cpl5_r)))
    else $error("compare high not reloaded");

    a_force_trip:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        force_trip |=> o_watchdog_reset)
    else $error("forced reset not requested");

    a_lock_sticks:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        lock_r |=> lock_r && wd_en)
    else $error("lock released before reset");

    a_overflow_flag:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wrap |=> cf_r)
    else $error("overflow flag not set on wrap");

    a_reset_cause:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_watchdog_reset |-> $past(wd_en))
    else $error("reset request with watchdog off");

    c_timeout:
    cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        quiet_r && o_watchdog_reset);

    c_forced:
    cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        force_trip ##1 o_watchdog_reset);

    c_disable:
    cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wd_en ##1 !wd_en);

    c_lock:
    cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        $rose(lock_r));
endmodule : counter_array_watchdog

// ===== rtl/counter_array_pkg.sv
// Notes on behaviour
// - enable bit makes channel 5 the watchdog
// - compare high byte; low byte is offset
// - watchdog enabled after every reset
// - reset: sysclk/12, counter low, offset zero
// - default timeout 256 ticks, 3072 cycles
// - watchdog forces shared counter running
// - counter byte writes ignored while enabled
// - timebase and idle-suspend frozen while enabled
// - channel 5 forced timer mode, mode locked
// - run bit writes cannot stop counter
// - run bit reads zero unless software set
// - low overflow with high match: reset
// - compare high write loads high plus offset
// - timeout is 256*offset plus 256-low
// - writing channel 5 flag forces reset
// - enable or lock enables; lock sticks
// - unlocked: clearing enable disables watchdog
// - overflow flag bit 7 on 16-bit wrap
// - bit 6 runs counter, watchdog overrides
// - bits 5:0 set by channel match
// - enabled: other mode bits unchangeable
// - timebase codes: div12,div4,t0,ext,clk,ext/8
// - idle-suspend halts counter in idle
package counter_array_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL    = 8'hd8;
    localparam logic [7:0] ADDR_MODE       = 8'hd9;
    localparam logic [7:0] ADDR_CH5_MODE   = 8'hde;
    localparam logic [7:0] ADDR_COUNT_LOW  = 8'he9;
    localparam logic [7:0] ADDR_CH5_LOW    = 8'hee;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hf9;
    localparam logic [7:0] ADDR_CH5_HIGH   = 8'hfe;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_OVF_BIT  = 7;
    localparam int CTL_RUN_BIT  = 6;
    localparam int CH5_FLAG_BIT = 5;
    localparam int NUM_CHANNELS = 6;
    localparam int MODE_IDLE_BIT = 7;
    localparam int MODE_WATCHDOG_ENABLE_BIT_BIT = 6;
    localparam int MODE_LOCK_BIT = 5;
    localparam int MODE_TB_LSB   = 1;
    localparam int MODE_TB_MSB   = 3;
    localparam int MODE_OIE_BIT  = 0;
    localparam int CH5_MAT_BIT   = 3;
    localparam int TB_W          = 3;
    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [7:0]  BYTE_MAX       = 8'hff;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;
    localparam logic        WATCHDOG_ENABLE_BIT_RESET     = 1'b1;
    localparam logic [7:0]  SW_TIMER_MODE  = 8'h48;
    localparam logic [3:0]  SYS_DIV12      = 4'hc;
    localparam logic [3:0]  SYS_DIV4       = 4'h4;
    localparam logic [3:0]  EXT_DIV8       = 4'h8;
    localparam int          TICKS_DEFAULT  = 256;
    localparam int          DEFAULT_CYCLES = TICKS_DEFAULT * 12;
    // ------------------------------------------------------------
    // timebase select codes
    // ------------------------------------------------------------
    localparam logic [2:0] TB_DIV12    = 3'h0;
    localparam logic [2:0] TB_DIV4     = 3'h1;
    localparam logic [2:0] TB_TIMER0   = 3'h2;
    localparam logic [2:0] TB_EXT_FALL = 3'h3;
    localparam logic [2:0] TB_SYSCLK   = 3'h4;
    localparam logic [2:0] TB_EXT_DIV8 = 3'h5;
endpackage : counter_array_pkg

// ===== rtl/counter_tick_gen.sv
`timescale 1ns/10ps
module counter_tick_gen #(
    parameter logic [3:0] DIV12 = counter_array_pkg::SYS_DIV12,
    parameter logic [3:0] DIV4  = counter_array_pkg::SYS_DIV4,
    parameter logic [3:0] EXTD  = counter_array_pkg::EXT_DIV8
) (
    input  wire logic       i_core_clk,     // system clock
    input  wire logic       i_rst_b,        // sync reset, low
    input  wire logic       i_run,          // counter may advance
    input  wire logic [counter_array_pkg::TB_W-1:0] i_timebase_sel, // src
    input  wire logic       i_timer0_ovf,   // timer 0 overflow pulse
    input  wire logic       i_ext_count,    // external count input
    input  wire logic       i_ext_clk,      // external clock level
    output logic            o_tick          // one counter clock
);
    import counter_array_pkg::*;

    logic [3:0] prescale_r, prescale_nxt;
    logic [3:0] ext_cnt_r, ext_cnt_nxt;
    logic       cnt_prev_r, ext_prev_r, tick_r, tick_nxt;
    logic [3:0] div;
    logic       pre_wrap, fall, rise, ext_wrap;

    // ------------------------------------------------------------
    // timebase selection and prescaling
    // ------------------------------------------------------------
    always_comb
    begin
        div = (i_timebase_sel == TB_DIV4) ? DIV4 : DIV12;
        pre_wrap = (prescale_r >= 4'(div - 4'h1));
        fall = cnt_prev_r & ~i_ext_count;
        rise = ~ext_prev_r & i_ext_clk;
        ext_wrap = (ext_cnt_r == 4'(EXTD - 4'h1));
        prescale_nxt = prescale_r;
        ext_cnt_nxt = ext_cnt_r;
        if (i_run)
        begin
            prescale_nxt = pre_wrap ? 4'h0 : 4'(prescale_r + 4'h1);
            if (rise)
                ext_cnt_nxt = ext_wrap ? 4'h0 : 4'(ext_cnt_r + 4'h1);
        end
        case (i_timebase_sel)
            TB_DIV12, TB_DIV4: tick_nxt = i_run & pre_wrap;
            TB_TIMER0:         tick_nxt = i_run & i_timer0_ovf;
            TB_EXT_FALL:       tick_nxt = i_run & fall;
            TB_SYSCLK:         tick_nxt = i_run;
            TB_EXT_DIV8:       tick_nxt = i_run & rise & ext_wrap;
            default:           tick_nxt = 1'b0;
        endcase
    end

    // register prescaler and edge history
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            prescale_r <= 4'h0;
            ext_cnt_r  <= 4'h0;
            cnt_prev_r <= 1'b0;
            ext_prev_r <= 1'b0;
            tick_r     <= 1'b0;
        end
        else
        begin
            prescale_r <= prescale_nxt;
            ext_cnt_r  <= ext_cnt_nxt;
            cnt_prev_r <= i_ext_count;
            ext_prev_r <= i_ext_clk;
            tick_r     <= tick_nxt;
        end
    end

    assign o_tick = tick_r;
endmodule : counter_tick_gen

// ===== rtl/watchdog_trip.sv
`timescale 1ns/10ps
module watchdog_trip (
    input  wire logic       i_core_clk,     // system clock
    input  wire logic       i_rst_b,        // sync reset, low
    input  wire logic       i_enable,       // watchdog enabled
    input  wire logic       i_low_ovf,      // counter low byte wraps
    input  wire logic [7:0] i_count_high,   // counter high byte
    input  wire logic [7:0] i_compare_high, // watchdog compare byte
    input  wire logic       i_force,        // software forced trip
    output logic            o_reset_req     // reset request pulse
);
    import counter_array_pkg::*;

    logic req_r, req_nxt;

    // compare high bytes on low byte overflow
    always_comb
    begin
        req_nxt = i_enable &
                  ((i_low_ovf & (i_compare_high == i_count_high))
                   | i_force);
    end

    // one-cycle request to the reset controller
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            req_r <= 1'b0;
        else
            req_r <= req_nxt;
    end

    assign o_reset_req = req_r;
endmodule : watchdog_trip

// ===== sim/reset_ctrl_model.sv
`timescale 1ns/10ps
module reset_ctrl_model (
    input  wire logic i_core_clk, // system clock
    input  wire logic i_dev_rst_b, // device reset seen, low
    input  wire logic i_req,      // watchdog reset request
    output logic      o_rst_b,    // system reset out, low
    output int        o_trips,    // requests taken
    output int        o_at,       // cycle of last request
    output int        o_width     // longest request, cycles
);
    int cyc = 0;
    int run = 0;
    int hold = 0;
    // hold the system in reset for three cycles after each request
    assign o_rst_b = (hold == 0);
    // time requests from release of the device reset
    always @(posedge i_core_clk)
    begin
        cyc <= i_dev_rst_b ? cyc + 1 : 0;
        run <= i_req ? run + 1 : 0;
        if (run + 1 > o_width && i_req)
            o_width <= run + 1;
        if (i_req && run == 0)
        begin
            o_trips <= o_trips + 1;
            o_at    <= cyc;
            hold    <= 3;
        end
        else if (hold > 0)
            hold <= hold - 1;
    end
    initial
    begin
        o_trips = 0;
        o_at    = 0;
        o_width = 0;
    end
endmodule : reset_ctrl_model

// ===== sim/counter_array_watchdog_bench.sv
`timescale 1ns/10ps
module counter_array_watchdog_bench;
    import counter_array_pkg::*;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       sys_rst_b;
    logic       dev_rst_b;
    logic [7:0] addr = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [4:0] match = 5'h00;
    logic       idle = 1'b0, t0 = 1'b0, ecnt = 1'b0, eclk = 1'b0;
    logic       wd_rst;
    logic       irq;
    logic       active;
    int         trips, at, width, n;
    int         error_cnt = 0;
    int         tests_run = 0;
    // ------------------------------------------------------------
    // clock, reset and instances
    // ------------------------------------------------------------
    always #4 clk = ~clk;
    assign dev_rst_b = rst_b & sys_rst_b;
    counter_array_watchdog DUT (.i_core_clk(clk), .i_rst_b(dev_rst_b),
        .i_sfr_addr(addr), .i_sfr_wr(wr_en), .i_sfr_rd(rd_en),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_cpu_idle(idle),
        .i_timer0_ovf(t0), .i_ext_count(ecnt), .i_ext_clk(eclk),
        .i_chan_match(match), .o_watchdog_reset(wd_rst),
        .o_counter_irq(irq), .o_watchdog_active(active));
    reset_ctrl_model sysctl (.i_core_clk(clk), .i_dev_rst_b(dev_rst_b),
        .i_req(wd_rst), .o_rst_b(sys_rst_b), .o_trips(trips), .o_at(at),
        .o_width(width));
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("tests run %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        check({8'h00, rdata}, {8'h00, exp});
    endtask : rdchk
    task automatic wait_trip(input int want, input int lim, output int c);
        for (c = 0; c < lim && trips < want; c++)
            @(posedge clk);
        if (trips < want)
        begin
            error_cnt++;
            results();
        end
        repeat (6) @(posedge clk);
    endtask : wait_trip
    // one high and one low cycle on every tick source pin
    task automatic pulses(input int cnt);
        repeat (cnt)
        begin
            t0   <= 1'b1;
            ecnt <= 1'b1;
            eclk <= 1'b1;
            @(posedge clk);
            t0   <= 1'b0;
            ecnt <= 1'b0;
            eclk <= 1'b0;
            @(posedge clk);
        end
    endtask : pulses
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(ADDR_MODE, 8'h40);
        rdchk(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_CH5_LOW, 8'h00);
        rdchk(ADDR_CH5_MODE, SW_TIMER_MODE);
        wr(ADDR_CH5_MODE, 8'h00);
        rdchk(ADDR_CH5_MODE, SW_TIMER_MODE);
        wr(ADDR_COUNT_HIGH, 8'haa);
        rdchk(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_MODE, 8'hc3);
        rdchk(ADDR_MODE, 8'h40);
        wr(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_COUNT_LOW, 8'h01);
        n = rdata;
        repeat (22) @(posedge clk);
        rdchk(ADDR_COUNT_LOW, 8'(n + 2));
        wait_trip(1, 4000, n);
        check(16'(at), 16'(DEFAULT_CYCLES + 1));
        check(16'(width), 16'h0001);
        rdchk(ADDR_MODE, 8'h40);
        wr(ADDR_MODE, 8'h00);
        check({15'h0, active}, 16'h0000);
        wr(ADDR_MODE, 8'h09);
        wr(ADDR_COUNT_LOW, 8'hf0);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_CONTROL, 8'h40);
        repeat (30) @(posedge clk);
        rdchk(ADDR_CONTROL, 8'hc0);
        check({15'h0, irq}, 16'h0001);
        wr(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_COUNT_HIGH, 8'h00);
        match <= 5'h04;
        @(posedge clk);
        match <= 5'h00;
        rdchk(ADDR_CONTROL, 8'h04);
        wr(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_CONTROL, 8'h00);
        wr(ADDR_MODE, 8'h88);
        wr(ADDR_COUNT_LOW, 8'h00);
        idle <= 1'b1;
        wr(ADDR_CONTROL, 8'h40);
        repeat (8) @(posedge clk);
        rdchk(ADDR_COUNT_LOW, 8'h00);
        idle <= 1'b0;
        repeat (4) @(posedge clk);
        rdchk(ADDR_COUNT_LOW, 8'h03);
        wr(ADDR_CONTROL, 8'h00);
        // timer 0, external falling edge and external divided by 8
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_MODE, (k == 2) ? 8'h0a : 8'(4 + 2 * k));
            wr(ADDR_COUNT_LOW, 8'h00);
            wr(ADDR_CONTROL, 8'h40);
            pulses(16);
            repeat (2) @(posedge clk);
            rdchk(ADDR_COUNT_LOW, (k == 2) ? 8'h02 : 8'h10);
            wr(ADDR_CONTROL, 8'h00);
        end
        wr(ADDR_MODE, 8'h08);
        wr(ADDR_CH5_LOW, 8'h02);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h10);
        wr(ADDR_MODE, 8'h48);
        wr(ADDR_CH5_HIGH, 8'h5a);
        rdchk(ADDR_CH5_HIGH, 8'h12);
        wait_trip(2, 1000, n);
        check(16'(n > 700 && n < 800), 16'h0001);
        wr(ADDR_MODE, 8'h20);
        wr(ADDR_MODE, 8'h00);
        rdchk(ADDR_MODE, 8'h20);
        check({15'h0, active}, 16'h0001);
        wr(ADDR_CONTROL, 8'h20);
        wait_trip(3, 4, n);
        check(16'(n), 16'h0001);
        wait_trip(4, 4000, n);
        check(16'(at), 16'(DEFAULT_CYCLES + 1));
        rdchk(ADDR_MODE, 8'h40);
        results();
    end
endmodule : counter_array_watchdog_bench
